/* sbs_pkg.sv */
// Package of the bank state sequencer: commands, states, timing counts.
// Assumes a 250 MHz core clock; times are in nanoseconds.
package sbs_pkg;
  localparam int CLOCK_MHZ = 250;
  localparam int NUM_BANKS = 4;
  localparam int BANK_W    = 2;
  // Printed times (ns)
  localparam int PRECHARGE_TIME_NS      = 15;
  localparam int ACT_TO_COL_DELAY_NS    = 15;
  localparam int WRITE_RECOVERY_NS      = 15;
  localparam int REFRESH_CYCLE_NS       = 70;
  localparam int MODE_SET_CYCLE_NS      = 15;
  localparam int BURST_LEN              = 4;
  // Cycle counts, rounded up
  localparam int PRECHARGE_CYC = (PRECHARGE_TIME_NS * CLOCK_MHZ + 999) / 1000;
  localparam int ACT_TO_COL_CYC = (ACT_TO_COL_DELAY_NS * CLOCK_MHZ + 999) / 1000;
  localparam int WRITE_RECOVERY_CYC = (WRITE_RECOVERY_NS * CLOCK_MHZ + 999) / 1000;
  localparam int REFRESH_CYC = (REFRESH_CYCLE_NS * CLOCK_MHZ + 999) / 1000;
  localparam int MODE_SET_CYC = (MODE_SET_CYCLE_NS * CLOCK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;
  // Pin order is {chip_select_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    SBS_CMD_DESELECT,
    SBS_CMD_NO_OPERATION,
    SBS_CMD_BURST_STOP,
    SBS_CMD_COLUMN_READ,
    SBS_CMD_COLUMN_WRITE,
    SBS_CMD_BANK_ACTIVATE,
    SBS_CMD_PRECHARGE,
    SBS_CMD_AUTO_REFRESH,
    SBS_CMD_MODE_REGISTER_SET
  } sbs_cmd_t;
  typedef enum logic [3:0] {
    SBS_IDLE,
    SBS_ROW_ACTIVATING,
    SBS_ROW_ACTIVE,
    SBS_READ,
    SBS_WRITE,
    SBS_READ_AP,
    SBS_WRITE_AP,
    SBS_PRECHARGING,
    SBS_WRITE_RECOVER,
    SBS_WRITE_RECOVER_AP,
    SBS_REFRESH,
    SBS_MODE_ACCESS
  } sbs_state_t;
endpackage

/* sbs_fifo_if.sv */
// Interface carrying the illegal-command log between sequencer and FIFO.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface sbs_fifo_if #(parameter int WIDTH = 12);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

/* sbs_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides.
// Assumes a single clock and asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module sbs_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input  wire logic clock,
  input  wire logic reset,
  sbs_fifo_if.sink  in_port,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push;
  wire              pop;

  // Handshakes on both sides
  assign in_port.ready = (count != (AW+1)'(DEPTH));
  assign out_valid     = (count != '0);
  assign out_data      = mem[rd_ptr];
  assign push          = in_port.valid && in_port.ready;
  assign pop           = out_valid && out_ready;

  // Storage write
  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_port.data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

/* sbs_bank_sequencer.sv */
// Per-bank command acceptance and transient state sequencing of an SDRAM.
// Assumes command pins sampled on the rising edge; clock enable held high.
`timescale 1ns/1ps
`default_nettype none
module sbs_bank_sequencer
  import sbs_pkg::*;
#(
  parameter int NUM_BANKS  = sbs_pkg::NUM_BANKS,
  parameter int BURST_LEN  = sbs_pkg::BURST_LEN,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                      clock,
  input  wire logic                      reset,
  input  wire logic                      chip_select_n,
  input  wire logic                      ras_n,
  input  wire logic                      cas_n,
  input  wire logic                      we_n,
  input  wire logic [sbs_pkg::BANK_W-1:0] bank_address,
  input  wire logic                      auto_precharge_bit,
  output var  logic [4*NUM_BANKS-1:0]    bank_state,
  output var  logic                      illegal_seen,
  output var  logic                      log_valid,
  input  wire logic                      log_ready,
  output var  logic [11:0]               log_data
);
  import sbs_pkg::*;

  // Synchronised pins
  logic [6:0] pin_meta;
  logic [6:0] pin_sync;
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      pin_meta <= 7'h7F;
      pin_sync <= 7'h7F;
    end
    else
    begin
      pin_meta <= {chip_select_n, ras_n, cas_n, we_n, bank_address,
                   auto_precharge_bit};
      pin_sync <= pin_meta;
    end
  end

  // Command decoding from the strobe pattern
  function automatic sbs_cmd_t decode(input logic [3:0] pins);
    sbs_cmd_t c;
    c = SBS_CMD_DESELECT;
    if (!pins[3])
    begin
      case (pins[2:0])
        3'h7:    c = SBS_CMD_NO_OPERATION;
        3'h6:    c = SBS_CMD_BURST_STOP;
        3'h5:    c = SBS_CMD_COLUMN_READ;
        3'h4:    c = SBS_CMD_COLUMN_WRITE;
        3'h3:    c = SBS_CMD_BANK_ACTIVATE;
        3'h2:    c = SBS_CMD_PRECHARGE;
        3'h1:    c = SBS_CMD_AUTO_REFRESH;
        default: c = SBS_CMD_MODE_REGISTER_SET;
      endcase
    end
    return c;
  endfunction

  // Decoded command and its address fields
  wire sbs_cmd_t          cmd     = decode(pin_sync[6:3]);
  wire [BANK_W-1:0]       cmd_bank = pin_sync[2:1];
  wire                    cmd_ap   = pin_sync[0];
  wire                    cmd_idle = (cmd == SBS_CMD_DESELECT) ||
                                     (cmd == SBS_CMD_NO_OPERATION);

  // Per-bank state machines
  logic [NUM_BANKS-1:0] bank_illegal;
  logic                 illegal_any;
  sbs_fifo_if #(.WIDTH(12)) log_if ();

  genvar b;
  generate
    for (b = 0; b < NUM_BANKS; b++)
    begin : g_bank
      sbs_state_t       state;
      sbs_state_t       next_state;
      logic [CNT_W-1:0] timer;
      logic [CNT_W-1:0] next_timer;
      logic             next_illegal;
      wire              hit  = (cmd_bank == BANK_W'(b));
      wire              done = (timer <= CNT_W'(1));
      wire              dec  = (timer != '0);

      // Next state per bank; refresh and mode set enter every idle bank, and refuse on every bank in them, regardless of bank address
      always_comb
      begin
        next_state   = state;
        next_timer   = dec ? timer - CNT_W'(1) : timer;
        next_illegal = 1'b0;
        case (state)
          SBS_IDLE:
          begin
            if (cmd == SBS_CMD_BANK_ACTIVATE && hit)
            begin
              next_state = SBS_ROW_ACTIVATING;
              next_timer = CNT_W'(ACT_TO_COL_CYC);
            end
            else if (cmd == SBS_CMD_AUTO_REFRESH)
            begin
              next_state = SBS_REFRESH;
              next_timer = CNT_W'(REFRESH_CYC);
            end
            else if (cmd == SBS_CMD_MODE_REGISTER_SET)
            begin
              next_state = SBS_MODE_ACCESS;
              next_timer = CNT_W'(MODE_SET_CYC);
            end
          end
          SBS_ROW_ACTIVE, SBS_READ, SBS_WRITE:
          begin
            if (hit && (cmd == SBS_CMD_COLUMN_READ ||
                        cmd == SBS_CMD_COLUMN_WRITE))
            begin
              next_timer = CNT_W'(BURST_LEN);
              if (cmd == SBS_CMD_COLUMN_READ)
                next_state = cmd_ap ? SBS_READ_AP : SBS_READ;
              else
                next_state = cmd_ap ? SBS_WRITE_AP : SBS_WRITE;
            end
            else if (hit && cmd == SBS_CMD_PRECHARGE)
            begin
              next_state = SBS_PRECHARGING;
              next_timer = CNT_W'(PRECHARGE_CYC);
            end
            else if (hit && cmd == SBS_CMD_BURST_STOP)
            begin
              next_state = SBS_ROW_ACTIVE;
              next_timer = '0;
            end
            else if (state == SBS_READ && done)
              next_state = SBS_ROW_ACTIVE;
            else if (state == SBS_WRITE && done)
            begin
              next_state = SBS_WRITE_RECOVER;
              next_timer = CNT_W'(WRITE_RECOVERY_CYC);
            end
          end
          SBS_READ_AP:
          begin
            if (hit && !cmd_idle)
              next_illegal = 1'b1;
            if (done)
            begin
              next_state = SBS_PRECHARGING;
              next_timer = CNT_W'(PRECHARGE_CYC);
            end
          end
          SBS_WRITE_AP:
          begin
            if (hit && !cmd_idle)
              next_illegal = 1'b1;
            if (done)
            begin
              next_state = SBS_WRITE_RECOVER_AP;
              next_timer = CNT_W'(WRITE_RECOVERY_CYC);
            end
          end
          SBS_PRECHARGING:
          begin
            if (hit && !cmd_idle && cmd != SBS_CMD_PRECHARGE)
              next_illegal = 1'b1;
            if (done)
              next_state = SBS_IDLE;
          end
          SBS_ROW_ACTIVATING:
          begin
            if (hit && !cmd_idle)
              next_illegal = 1'b1;
            if (done)
              next_state = SBS_ROW_ACTIVE;
          end
          SBS_WRITE_RECOVER:
          begin
            if (hit && (cmd == SBS_CMD_COLUMN_READ ||
                        cmd == SBS_CMD_COLUMN_WRITE))
            begin
              next_timer = CNT_W'(BURST_LEN);
              if (cmd == SBS_CMD_COLUMN_READ)
                next_state = cmd_ap ? SBS_READ_AP : SBS_READ;
              else
                next_state = cmd_ap ? SBS_WRITE_AP : SBS_WRITE;
            end
            else if (done)
              next_state = SBS_ROW_ACTIVE;
            // Refused command leaves the recovery timing alone
            if (hit && !cmd_idle && cmd != SBS_CMD_BURST_STOP &&
                cmd != SBS_CMD_COLUMN_READ && cmd != SBS_CMD_COLUMN_WRITE)
              next_illegal = 1'b1;
          end
          SBS_WRITE_RECOVER_AP:
          begin
            if (hit && cmd == SBS_CMD_BURST_STOP)
            begin
              // Pending precharge dropped, recovery keeps running
              next_state = SBS_WRITE_RECOVER;
            end
            else if (done)
            begin
              next_state = SBS_PRECHARGING;
              next_timer = CNT_W'(PRECHARGE_CYC);
            end
            if (hit && !cmd_idle && cmd != SBS_CMD_BURST_STOP)
              next_illegal = 1'b1;
          end
          SBS_REFRESH:
          begin
            if (!cmd_idle && cmd != SBS_CMD_BURST_STOP)
              next_illegal = 1'b1;
            if (done)
              next_state = SBS_IDLE;
          end
          SBS_MODE_ACCESS:
          begin
            if (!cmd_idle && cmd != SBS_CMD_BURST_STOP)
              next_illegal = 1'b1;
            if (done)
              next_state = SBS_IDLE;
          end
          default:
          begin
            next_state = SBS_IDLE;
            next_timer = '0;
          end
        endcase
      end

      // Bank state and interval timer
      always_ff @(posedge clock or posedge reset)
      begin
        if (reset)
        begin
          state <= SBS_IDLE;
          timer <= '0;
        end
        else
        begin
          state <= next_state;
          timer <= next_timer;
        end
      end

      assign bank_illegal[b] = next_illegal;

      // Registered state code per bank
      always_ff @(posedge clock or posedge reset)
      begin
        if (reset)
          bank_state[4*b +: 4] <= 4'h0;
        else
          bank_state[4*b +: 4] <= 4'(next_state);
      end
    end
  endgenerate

  // Log of refused commands; drops report when full
  assign illegal_any    = |bank_illegal;
  assign log_if.valid   = illegal_any;
  assign log_if.data    = {cmd, cmd_bank, 2'h0, 4'(bank_illegal)};

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      illegal_seen <= 1'b0;
    else
      illegal_seen <= illegal_any;
  end

  sbs_fifo #(.WIDTH(12), .DEPTH(FIFO_DEPTH)) u_log (
    .clock     (clock),
    .reset     (reset),
    .in_port   (log_if),
    .out_valid (log_valid),
    .out_ready (log_ready),
    .out_data  (log_data)
  );
endmodule
`default_nettype wire

/* sbs_bank_sequencer_assertions.sv */
// Checker of the bank sequencer ports: legality and state dwell times.
// Assumes pins pass two sync flops, then one register to bank_state.
`timescale 1ns/1ps
`default_nettype none
module sbs_bank_sequencer_assertions
  import sbs_pkg::*;
#(
  parameter int NUM_BANKS = 4
) (
  input wire logic                       clock,
  input wire logic                       reset,
  input wire logic                       chip_select_n,
  input wire logic                       ras_n,
  input wire logic                       cas_n,
  input wire logic                       we_n,
  input wire logic [sbs_pkg::BANK_W-1:0] bank_address,
  input wire logic                       auto_precharge_bit,
  input wire logic [4*NUM_BANKS-1:0]     bank_state,
  input wire logic                       illegal_seen
);
  // Pins as the decoder sees them, and the state dwell count
  logic [6:0] p1;
  logic [6:0] p2;
  logic [1:0] b3;
  logic [3:0] st_q;
  logic [7:0] cnt;
  wire  [3:0] cmd = p2[6:3];
  wire  [1:0] ba = p2[2:1];
  wire  [3:0] sel = bank_state[ba*4 +: 4];
  wire  [3:0] sel3 = bank_state[b3*4 +: 4];
  wire  [3:0] st0 = bank_state[3:0];
  wire        left = st0 != st_q;
  wire        is_nop = cmd[3] | (cmd == 4'h7);
  wire        is_bst = cmd == 4'h6;
  wire        is_pre = cmd == 4'h2;
  wire        per_bank = !cmd[3] && (cmd[2] ^ cmd[1]);
  function automatic logic near(logic [7:0] c, int n);
    return c == 8'(n);
  endfunction
  // Delay the pins like the design does
  always_ff @(posedge clock or posedge reset)
    if (reset)
    begin
      p1 <= 7'h7F;
      p2 <= 7'h7F;
      b3 <= 2'h0;
      st_q <= 4'h0;
      cnt <= 8'h00;
    end
    else
    begin
      p1 <= {chip_select_n, ras_n, cas_n, we_n, bank_address,
             auto_precharge_bit};
      p2 <= p1;
      b3 <= p2[2:1];
      st_q <= st0;
      cnt <= left ? 8'h01 : cnt + 8'h01;
    end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  act_idle_a: assert property (
    sel == SBS_IDLE && cmd == 4'h3 |=> sel3 == SBS_ROW_ACTIVATING)
    else $error("activate not taken");
  act_bad_a: assert property (
    sel == SBS_ROW_ACTIVATING && (per_bank || is_bst) |=> illegal_seen)
    else $error("command in activating not refused");
  nop_clean_a: assert property (
    is_nop |=> !illegal_seen) else $error("no-op flagged");
  pre_nop_a: assert property (
    sel == SBS_PRECHARGING && is_pre |=> !illegal_seen)
    else $error("precharge in precharging flagged");
  rec_bst_a: assert property (
    sel == SBS_WRITE_RECOVER && is_bst |=> !illegal_seen)
    else $error("burst stop in recovery flagged");
  rec_read_a: assert property (
    sel == SBS_WRITE_RECOVER && cmd == 4'h5
    |=> sel3 inside {SBS_READ, SBS_READ_AP})
    else $error("read in recovery not started");
  rdap_bst_a: assert property (
    sel == SBS_READ_AP && is_bst |=> illegal_seen)
    else $error("burst stop in read ap not refused");
  bst_cancel_a: assert property (
    sel == SBS_WRITE_RECOVER_AP && is_bst
    |=> sel3 inside {SBS_WRITE_RECOVER, SBS_ROW_ACTIVE})
    else $error("auto precharge not cancelled");
  act_time_a: assert property (
    st_q == SBS_ROW_ACTIVATING && left
    |-> st0 == SBS_ROW_ACTIVE && near(cnt, ACT_TO_COL_CYC))
    else $error("activate dwell wrong");
  pre_time_a: assert property (
    st_q == SBS_PRECHARGING && left
    |-> st0 == SBS_IDLE && near(cnt, PRECHARGE_CYC))
    else $error("precharge dwell wrong");
  ref_time_a: assert property (
    st_q == SBS_REFRESH && left
    |-> st0 == SBS_IDLE && near(cnt, REFRESH_CYC))
    else $error("refresh dwell wrong");
  mode_time_a: assert property (
    st_q == SBS_MODE_ACCESS && left
    |-> st0 == SBS_IDLE && near(cnt, MODE_SET_CYC))
    else $error("mode set dwell wrong");
  // Main scenarios
  cover property (st0 == SBS_REFRESH && illegal_seen);
  cover property (st_q == SBS_WRITE_RECOVER_AP && st0 == SBS_WRITE_RECOVER);
  cover property (st_q == SBS_MODE_ACCESS && st0 == SBS_IDLE);
endmodule
bind sbs_bank_sequencer sbs_bank_sequencer_assertions #(
  .NUM_BANKS(NUM_BANKS)
) chk (
  .clock(clock),
  .reset(reset),
  .chip_select_n(chip_select_n),
  .ras_n(ras_n),
  .cas_n(cas_n),
  .we_n(we_n),
  .bank_address(bank_address),
  .auto_precharge_bit(auto_precharge_bit),
  .bank_state(bank_state),
  .illegal_seen(illegal_seen)
);
`default_nettype wire

/* sbs_ctrl_model.sv */
// Controller model: puts commands on the strobes, drains the log.
// Assumes clock enable is held high; unused address lines toggle.
`timescale 1ns/1ps
`default_nettype none
module sbs_ctrl_model
  import sbs_pkg::*;
(
  input  wire sbs_cmd_t   cmd,
  input  wire logic [1:0] bank,
  input  wire logic       ap,
  input  wire logic       stall,
  output var  logic       chip_select_n,
  output var  logic       ras_n,
  output var  logic       cas_n,
  output var  logic       we_n,
  output var  logic [1:0] bank_address,
  output var  logic       auto_precharge_bit,
  output var  logic       log_ready
);
  // Strobe codes in command order; unused lines show inverted value
  localparam logic [3:0] LUT [9] = '{4'hF, 4'h7, 4'h6, 4'h5, 4'h4,
                                     4'h3, 4'h2, 4'h1, 4'h0};
  wire use_ba = cmd inside {SBS_CMD_BURST_STOP, SBS_CMD_COLUMN_READ,
    SBS_CMD_COLUMN_WRITE, SBS_CMD_BANK_ACTIVATE, SBS_CMD_PRECHARGE};
  wire use_ap = cmd inside {SBS_CMD_COLUMN_READ, SBS_CMD_COLUMN_WRITE,
    SBS_CMD_PRECHARGE};
  assign {chip_select_n, ras_n, cas_n, we_n} = LUT[cmd];
  assign bank_address = use_ba ? bank : ~bank;
  assign auto_precharge_bit = use_ap ? ap : ~ap;
  assign log_ready = !stall;
endmodule
`default_nettype wire

/* sbs_bank_sequencer_tb.sv */
// Testbench of the bank sequencer through the controller model.
// Assumes the checker is bound to the design by its own file.
`timescale 1ns/1ps
`default_nettype none
module sbs_bank_sequencer_tb;
  import sbs_pkg::*;
  logic        clock;
  logic        reset;
  sbs_cmd_t    cmd;
  logic [1:0]  bank;
  logic        ap;
  logic        stall;
  wire         cs_n, ras_n, cas_n, we_n, apb, illegal, lv, lr;
  wire  [1:0]  ba;
  wire  [15:0] st;
  wire  [11:0] ld;
  logic [11:0] q [$];
  int          n_errors;
  int          checked;
  int          n_ill;
  sbs_ctrl_model ctrl (.cmd(cmd), .bank(bank), .ap(ap), .stall(stall),
    .chip_select_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bank_address(ba), .auto_precharge_bit(apb), .log_ready(lr));
  sbs_bank_sequencer dut (.clock(clock), .reset(reset),
    .chip_select_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bank_address(ba), .auto_precharge_bit(apb), .bank_state(st),
    .illegal_seen(illegal), .log_valid(lv), .log_ready(lr),
    .log_data(ld));
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Count refusals and log pops
  always @(negedge clock)
  begin
    if (illegal === 1'b1)
      n_ill++;
    if (lv === 1'b1 && lr === 1'b1)
      q.push_back(ld);
  end
  task automatic conclude();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk_val(string name, logic [11:0] exp, logic [11:0] got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic wait_st(int b, logic [3:0] exp, int lim);
    for (int i = 0; i < lim && st[b*4 +: 4] !== exp; i++)
      @(negedge clock);
    checked++;
    if (st[b*4 +: 4] !== exp)
    begin
      n_errors++;
      $display("BAD state%0d exp %h got %h", b, exp, st[b*4 +: 4]);
      conclude();
    end
  endtask
  task automatic send(sbs_cmd_t c, logic [1:0] b, logic a, int n);
    @(posedge clock);
    cmd <= c;
    bank <= b;
    ap <= a;
    repeat (n) @(posedge clock);
    cmd <= SBS_CMD_NO_OPERATION;
  endtask
  task automatic try_cmd(sbs_cmd_t c, logic [1:0] b, int exp);
    int base;
    base = n_ill;
    send(c, b, 1'b0, 1);
    repeat (3) @(negedge clock);
    @(posedge clock);
    chk_val("illegal", 12'(exp), 12'(n_ill - base));
  endtask
  // Refused read while the row opens
  task automatic s_activate();
    send(SBS_CMD_BANK_ACTIVATE, 2'h0, 1'b0, 1);
    wait_st(0, SBS_ROW_ACTIVATING, 6);
    try_cmd(SBS_CMD_COLUMN_READ, 2'h0, 1);
    wait_st(0, SBS_ROW_ACTIVE, 8);
  endtask
  // Write with auto precharge through recovery to idle
  task automatic s_write_ap();
    send(SBS_CMD_COLUMN_WRITE, 2'h0, 1'b1, 1);
    wait_st(0, SBS_WRITE_AP, 6);
    try_cmd(SBS_CMD_BURST_STOP, 2'h0, 1);
    wait_st(0, SBS_WRITE_RECOVER_AP, 6);
    wait_st(0, SBS_PRECHARGING, 6);
    try_cmd(SBS_CMD_PRECHARGE, 2'h0, 0);
    wait_st(0, SBS_IDLE, 8);
  endtask
  // Burst stop cancels auto precharge; plain recovery
  task automatic s_cancel();
    send(SBS_CMD_BANK_ACTIVATE, 2'h0, 1'b0, 1);
    wait_st(0, SBS_ROW_ACTIVE, 12);
    send(SBS_CMD_COLUMN_WRITE, 2'h0, 1'b1, 1);
    wait_st(0, SBS_WRITE_RECOVER_AP, 12);
    send(SBS_CMD_BURST_STOP, 2'h0, 1'b0, 1);
    wait_st(0, SBS_ROW_ACTIVE, 12);
    send(SBS_CMD_COLUMN_WRITE, 2'h0, 1'b0, 1);
    wait_st(0, SBS_WRITE_RECOVER, 12);
    try_cmd(SBS_CMD_BURST_STOP, 2'h0, 0);
    wait_st(0, SBS_ROW_ACTIVE, 8);
    send(SBS_CMD_COLUMN_WRITE, 2'h0, 1'b0, 1);
    wait_st(0, SBS_WRITE_RECOVER, 12);
    // Read accepted at once during write recovery
    send(SBS_CMD_COLUMN_READ, 2'h0, 1'b0, 1);
    wait_st(0, SBS_READ, 6);
    wait_st(0, SBS_ROW_ACTIVE, 8);
    send(SBS_CMD_PRECHARGE, 2'h0, 1'b0, 1);
    wait_st(0, SBS_IDLE, 12);
  endtask
  // Read with auto precharge refuses burst stop
  task automatic s_read_ap();
    send(SBS_CMD_BANK_ACTIVATE, 2'h1, 1'b0, 1);
    wait_st(1, SBS_ROW_ACTIVE, 12);
    send(SBS_CMD_COLUMN_READ, 2'h1, 1'b1, 1);
    wait_st(1, SBS_READ_AP, 6);
    try_cmd(SBS_CMD_BURST_STOP, 2'h1, 1);
    wait_st(1, SBS_IDLE, 20);
  endtask
  // Refresh refuses activates; stalled log fills and drops
  task automatic s_refresh();
    int base;
    int pops;
    base = n_ill;
    pops = q.size();
    @(posedge clock);
    stall <= 1'b1;
    send(SBS_CMD_AUTO_REFRESH, 2'h0, 1'b0, 1);
    wait_st(0, SBS_REFRESH, 6);
    wait_st(3, SBS_REFRESH, 1);
    send(SBS_CMD_BANK_ACTIVATE, 2'h2, 1'b0, 10);
    wait_st(0, SBS_IDLE, 30);
    chk_val("refused", 12'd10, 12'(n_ill - base));
    @(posedge clock);
    stall <= 1'b0;
    for (int i = 0; i < 40 && q.size() - pops < 12; i++)
      @(posedge clock);
    chk_val("pops", 12'd8, 12'(q.size() - pops));
    // Refresh holds every bank, so all four refuse
    chk_val("entry", {4'(SBS_CMD_BANK_ACTIVATE), 2'h2, 2'h0, 4'hF},
      q[pops]);
  endtask
  // Mode set refuses refresh, then idles
  task automatic s_mode();
    send(SBS_CMD_MODE_REGISTER_SET, 2'h0, 1'b0, 1);
    wait_st(0, SBS_MODE_ACCESS, 6);
    try_cmd(SBS_CMD_AUTO_REFRESH, 2'h0, 1);
    wait_st(0, SBS_IDLE, 8);
  endtask
  initial
  begin
    cmd = SBS_CMD_DESELECT;
    bank = 2'h0;
    ap = 1'b0;
    stall = 1'b0;
    reset = 1'b1;
    n_errors = 0;
    checked = 0;
    n_ill = 0;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    s_activate();
    s_write_ap();
    s_cancel();
    s_read_ap();
    s_refresh();
    s_mode();
    conclude();
  end
endmodule
`default_nettype wire
